// file: verilog/mms_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MMS_REGS_SVH
`define MMS_REGS_SVH
// apb byte offsets, one aligned word each
`define MMS_OFF_ADDR 8'h00
`define MMS_OFF_DATA 8'h04
`define MMS_OFF_ACC 8'h08
`define MMS_OFF_XREG 8'h0C
`define MMS_OFF_YREG 8'h10
`define MMS_OFF_SP 8'h14
`define MMS_OFF_PSR 8'h18
`define MMS_OFF_PC 8'h1C
`define MMS_OFF_CMD 8'h20
`define MMS_OFF_STAT 8'h24
`define MMS_OFF_OPND 8'h28
`define MMS_OFF_EA 8'h2C
// memory map boundaries
`define MMS_ROM_BASE 16'hE800
`define MMS_SPEC_BASE 16'hFF00
`define MMS_VECT_BASE 16'hFFF4
`define MMS_RAM_TOP 16'h00BF
`define MMS_ZP_TOP 16'h00FF
`define MMS_ROM_BYTES 6144
`define MMS_RAM_BYTES 192
// vectors
`define MMS_VEC_HI 16'hFFFC
`define MMS_VEC_LO 16'hFFF4
// zero page peripheral locations (low byte)
`define MMS_PORT_BASE 8'hC0
`define MMS_INPORT 8'hCA
`define MMS_SIOMODE 8'hF6
`define MMS_INTCTL 8'hFE
`define MMS_TMRCTL 8'hFF
// field positions
`define MMS_STK_PAGE 4
`define MMS_SIO_SEL 2
`define MMS_PS_I 2
`define MMS_PS_T 5
`define MMS_REQ_HI 4
`define MMS_REQ_LO 5
// reset values and pin masks
`define MMS_DIR_RST 8'h00
`define MMS_PS_RST 8'h04
`define MMS_SIO_PINS 8'hF0
`define MMS_SIO_OUTS 8'hE0
// reset output stretch: least reset time in ns, clock period in ns
`define MMS_RST_MIN_NS 2000
`define MMS_CLK_NS 25
`define MMS_RST_CYC ((`MMS_RST_MIN_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`endif

// file: verilog/mms_pkg.sv
// shared types and memory region decoding
`include "mms_regs.svh"
package mms_pkg;
	typedef enum logic [2:0] {RG_RAM = 3'h0, RG_SFR = 3'h1, RG_NONE = 3'h2,
		RG_ROM = 3'h3, RG_SPECIAL = 3'h4, RG_VECTOR = 3'h5} mms_region_t;
	typedef enum logic [3:0] {CMD_NONE = 4'h0, CMD_TXS = 4'h1, CMD_PHA = 4'h2,
		CMD_PLA = 4'h3, CMD_PHP = 4'h4, CMD_PLP = 4'h5, CMD_JSR = 4'h6,
		CMD_RTS = 4'h7, CMD_RTI = 4'h8, CMD_IRQ = 4'hF} mms_cmd_t;
	typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_PUSH = 3'h1, ST_PULL = 3'h2,
		ST_VEC = 3'h3} mms_state_t;
	// region of a 16-bit address, highest region first
	function automatic mms_region_t mms_region(input logic [15:0] a);
		if (a >= `MMS_VECT_BASE)
			return RG_VECTOR;
		else if (a >= `MMS_SPEC_BASE)
			return RG_SPECIAL;
		else if (a >= `MMS_ROM_BASE)
			return RG_ROM;
		else if (a <= `MMS_RAM_TOP)
			return RG_RAM;
		else if (a <= `MMS_ZP_TOP)
			return RG_SFR;
		else
			return RG_NONE;
	endfunction
endpackage

// file: verilog/mms_port.sv
// one 8-bit bidirectional port with direction control and pin synchroniser
`timescale 1ns/100ps
module mms_port (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] dir, // 1 = output per bit
	input wire logic [7:0] data, // output latch
	input wire logic [7:0] alt_en, // bit taken over by alternate function
	input wire logic [7:0] alt_oe, // alternate drive enable
	input wire logic [7:0] alt_out, // alternate drive value
	input wire logic [7:0] pin_in, // pin level from outside
	output logic [7:0] pin_out_ff, // pin drive value
	output logic [7:0] pin_oe_ff, // pin drive enable
	output logic [7:0] pin_sync_ff // synchronised pin level
);
	logic [7:0] pin_meta_ff; // first sync stage, read only by second

	// drive: alternate function wins over the port latch per bit
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pin_out_ff <= 8'h00;
			pin_oe_ff <= 8'h00; // all inputs out of reset
		end
		else
		begin
			pin_out_ff <= (alt_en & alt_out) | (~alt_en & data);
			pin_oe_ff <= (alt_en & alt_oe) | (~alt_en & dir);
		end

	// two-stage synchroniser for outside levels
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pin_meta_ff <= 8'h00;
			pin_sync_ff <= 8'h00;
		end
		else
		begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
endmodule // mms_port

// file: verilog/mms_core.sv
// memory map, index addressing, stack engine and ports of the core
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "mms_regs.svh"
module mms_core (
	input wire logic pclk, // 40 MHz clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [39:0] port_pin_in, // five bidir ports, pin levels
	output wire logic [39:0] port_pin_out, // five bidir ports, drive
	output wire logic [39:0] port_pin_oe, // five bidir ports, enable
	input wire logic [7:0] input_only_port, // input-only port pins
	input wire logic external_irq_high_n, // high priority irq pin
	input wire logic external_irq_low_n, // low priority irq pin
	input wire logic serial_ready, // from serial unit
	input wire logic serial_clock, // from serial unit
	input wire logic serial_data_out, // from serial unit
	output logic serial_data_in, // to serial unit
	output logic serial_select, // serial function on port three
	output logic reset_out_n // reset to peripherals, active low
);
	import mms_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	logic pready_ff, pslverr_ff; // apb answer
	logic [31:0] prdata_ff; // apb read data
	logic [15:0] addr_ff, opnd_ff, vec_ff; // window, operand, vector
	logic [15:0] pc_ff; // program counter, high and low halves
	logic [7:0] acc_ff, x_ff, y_ff, sp_ff, ps_ff; // cpu registers
	logic [7:0] tmr_ctl_ff, sio_mode_ff; // zero page controls
	logic [1:0] int_en_ff; // irq enables, hi at bit 0
	logic req_hi_ff, req_lo_ff; // sticky irq requests
	logic [7:0] port_data_ff [0:4]; // port output latches
	logic [7:0] port_dir_ff [0:4]; // port direction registers
	logic [7:0] pin_sync [0:4]; // synchronised port pins
	logic [7:0] ram_ff [0:`MMS_RAM_BYTES-1]; // internal static ram
	logic [7:0] rom_ff [0:`MMS_ROM_BYTES-1]; // program memory image
	logic [7:0] inp_meta_ff, inp_sync_ff; // input-only port sync
	logic hi_meta_ff, hi_sync_ff, hi_prev_ff; // high irq pin sync
	logic lo_meta_ff, lo_sync_ff, lo_prev_ff; // low irq pin sync
	logic [6:0] rst_cnt_ff; // reset output stretch
	logic reset_out_n_ff, serial_data_in_ff; // pin outputs
	mms_state_t state_ff; // stack engine state
	mms_cmd_t op_ff; // operation in progress
	logic [1:0] step_ff; // byte index within operation

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign reset_out_n = reset_out_n_ff;
	assign serial_data_in = serial_data_in_ff;
	assign serial_select = sio_mode_ff[`MMS_SIO_SEL];

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	logic setup, wr_ok, busy, cmd_go, irq_take, sio_sel, last_step;
	logic mw_en; // memory write strobe
	logic [15:0] mw_addr; // memory write address
	logic [7:0] mw_data, push_byte, pull_byte; // stack bytes
	logic [31:0] rd_data; // apb read mux
	logic refuse; // apb error at setup
	mms_cmd_t cmd_in; // command written this cycle

	assign setup = psel && !penable;
	assign wr_ok = psel && penable && pready_ff && pwrite && !pslverr_ff;
	assign busy = state_ff != ST_IDLE;
	assign cmd_in = mms_cmd_t'(pwdata[3:0]);
	assign cmd_go = wr_ok && paddr == `MMS_OFF_CMD;
	assign sio_sel = sio_mode_ff[`MMS_SIO_SEL];
	// irq waits for the bus so an entry never starts during a transfer
	assign irq_take = !busy && !psel && !ps_ff[`MMS_PS_I] &&
		((req_hi_ff && int_en_ff[0]) || (req_lo_ff && int_en_ff[1]));

	// stack address: page bit above the pointer
	function automatic logic [15:0] stk_addr(input logic [7:0] s);
		return {7'h00, tmr_ctl_ff[`MMS_STK_PAGE], s};
	endfunction

	// bytes moved by each stack operation
	function automatic logic [1:0] n_bytes(input mms_cmd_t c);
		case (c)
			CMD_IRQ, CMD_RTI: return 2'h3;
			CMD_JSR, CMD_RTS: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction

	// zero page peripheral read
	function automatic logic [7:0] sfr_rd(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		for (int n = 0; n < 5; n++)
		begin
			if (a == 8'(`MMS_PORT_BASE + 2 * n))
				d = (port_dir_ff[n] & port_data_ff[n]) |
					(~port_dir_ff[n] & pin_sync[n]);
			if (a == 8'(`MMS_PORT_BASE + 2 * n + 1))
				d = port_dir_ff[n];
		end
		if (a == `MMS_INPORT)
			d = inp_sync_ff;
		if (a == `MMS_SIOMODE)
			d = sio_mode_ff;
		if (a == `MMS_INTCTL)
			d = {2'h0, req_lo_ff, req_hi_ff, 2'h0, int_en_ff};
		if (a == `MMS_TMRCTL)
			d = tmr_ctl_ff;
		return d;
	endfunction

	// read of any map address; unmapped reads as all ones
	function automatic logic [7:0] mem_rd(input logic [15:0] a);
		logic [7:0] d;
		d = 8'hFF;
		case (mms_region(a))
			RG_RAM: d = ram_ff[a[7:0]];
			RG_SFR: d = sfr_rd(a[7:0]);
			RG_ROM, RG_SPECIAL, RG_VECTOR:
				d = rom_ff[13'(a - `MMS_ROM_BASE)];
			default: d = 8'hFF;
		endcase
		return d;
	endfunction

	assign last_step = step_ff == n_bytes(op_ff) - 2'h1;
	assign pull_byte = mem_rd(stk_addr(8'(sp_ff + 8'h01)));

	// byte pushed at each step
	always_comb
	begin
		case (op_ff)
			CMD_PHA: push_byte = acc_ff;
			CMD_PHP: push_byte = ps_ff;
			default: // call and interrupt entry
				case (step_ff)
					2'h0: push_byte = pc_ff[15:8];
					2'h1: push_byte = pc_ff[7:0];
					default: push_byte = ps_ff;
				endcase
		endcase
	end

	// memory write port: stack engine has the ram while busy
	always_comb
	begin
		if (state_ff == ST_PUSH)
		begin
			mw_en = 1'b1;
			mw_addr = stk_addr(sp_ff);
			mw_data = push_byte;
		end
		else
		begin
			mw_en = wr_ok && paddr == `MMS_OFF_DATA;
			mw_addr = addr_ff;
			mw_data = pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: answer prepared in setup, ready in access phase
	always_comb
	begin
		refuse = paddr[1:0] != 2'h0 || paddr > `MMS_OFF_EA ||
			(busy && (pwrite || paddr == `MMS_OFF_DATA));
		case (paddr)
			`MMS_OFF_ADDR: rd_data = {16'h0000, addr_ff};
			`MMS_OFF_DATA: rd_data = {24'h00_0000, mem_rd(addr_ff)};
			`MMS_OFF_ACC: rd_data = {24'h00_0000, acc_ff};
			`MMS_OFF_XREG: rd_data = {24'h00_0000, x_ff};
			`MMS_OFF_YREG: rd_data = {24'h00_0000, y_ff};
			`MMS_OFF_SP: rd_data = {24'h00_0000, sp_ff};
			`MMS_OFF_PSR: rd_data = {24'h00_0000, ps_ff};
			`MMS_OFF_PC: rd_data = {16'h0000, pc_ff};
			`MMS_OFF_CMD: rd_data = {28'h000_0000, op_ff};
			`MMS_OFF_STAT: rd_data = {13'h0000, state_ff,
				ps_ff[`MMS_PS_T] ? x_ff : 8'h00,
				2'h0, req_lo_ff, req_hi_ff, mms_region(addr_ff), busy};
			`MMS_OFF_OPND: rd_data = {16'h0000, opnd_ff};
			`MMS_OFF_EA: rd_data = {16'(opnd_ff + {8'h00, y_ff}),
				16'(opnd_ff + {8'h00, x_ff})};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// no wait state: ready in the first access cycle of every transfer; errors decided at setup
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup && refuse;
			if (setup)
				prdata_ff <= refuse ? 32'h0000_0000 : rd_data;
		end

	////////////////////////////////////////////////////////////////////////
	// memories: no reset, contents are software's business
	always_ff @(posedge pclk)
		if (mw_en && mms_region(mw_addr) == RG_RAM)
			ram_ff[mw_addr[7:0]] <= mw_data;

	// program image loaded through the window; covers vectors too
	always_ff @(posedge pclk)
		if (mw_en && !busy && mms_region(mw_addr) >= RG_ROM)
			rom_ff[13'(mw_addr - `MMS_ROM_BASE)] <= mw_data;

	////////////////////////////////////////////////////////////////////////
	// zero page peripheral writes
	logic zp_wr;
	assign zp_wr = mw_en && !busy && mms_region(mw_addr) == RG_SFR;

	// port latches and directions, all inputs after reset
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			for (int n = 0; n < 5; n++)
			begin
				port_data_ff[n] <= 8'h00;
				port_dir_ff[n] <= `MMS_DIR_RST;
			end
		else if (zp_wr)
			for (int n = 0; n < 5; n++)
			begin
				if (mw_addr[7:0] == 8'(`MMS_PORT_BASE + 2 * n))
					port_data_ff[n] <= mw_data;
				if (mw_addr[7:0] == 8'(`MMS_PORT_BASE + 2 * n + 1))
					port_dir_ff[n] <= mw_data;
			end

	// timer control (stack page), serial mode, irq enables
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tmr_ctl_ff <= 8'h00;
			sio_mode_ff <= 8'h00;
			int_en_ff <= 2'h0;
		end
		else if (zp_wr)
		begin
			if (mw_addr[7:0] == `MMS_TMRCTL)
				tmr_ctl_ff <= mw_data;
			if (mw_addr[7:0] == `MMS_SIOMODE)
				sio_mode_ff <= mw_data;
			if (mw_addr[7:0] == `MMS_INTCTL)
				int_en_ff <= mw_data[1:0];
		end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers for irq inputs and the input-only port
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			{hi_meta_ff, hi_sync_ff, hi_prev_ff} <= 3'h7;
			{lo_meta_ff, lo_sync_ff, lo_prev_ff} <= 3'h7;
			inp_meta_ff <= 8'h00;
			inp_sync_ff <= 8'h00;
		end
		else
		begin
			{hi_meta_ff, hi_sync_ff, hi_prev_ff} <=
				{external_irq_high_n, hi_meta_ff, hi_sync_ff};
			{lo_meta_ff, lo_sync_ff, lo_prev_ff} <=
				{external_irq_low_n, lo_meta_ff, lo_sync_ff};
			inp_meta_ff <= input_only_port;
			inp_sync_ff <= inp_meta_ff;
		end

	// sticky requests on falling edge; a new edge beats any clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			req_hi_ff <= 1'b0;
			req_lo_ff <= 1'b0;
		end
		else
		begin
			if (hi_prev_ff && !hi_sync_ff)
				req_hi_ff <= 1'b1;
			else if ((irq_take && int_en_ff[0]) || (zp_wr &&
				mw_addr[7:0] == `MMS_INTCTL && !mw_data[`MMS_REQ_HI]))
				req_hi_ff <= 1'b0;
			if (lo_prev_ff && !lo_sync_ff)
				req_lo_ff <= 1'b1;
			else if ((irq_take && !(req_hi_ff && int_en_ff[0])) || (zp_wr &&
				mw_addr[7:0] == `MMS_INTCTL && !mw_data[`MMS_REQ_LO]))
				req_lo_ff <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////
	// stack engine: one byte per cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state_ff <= ST_IDLE;
			op_ff <= CMD_NONE;
			step_ff <= 2'h0;
			vec_ff <= `MMS_VEC_LO;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					step_ff <= 2'h0;
					if (irq_take)
					begin
						state_ff <= ST_PUSH;
						op_ff <= CMD_IRQ;
						vec_ff <= (req_hi_ff && int_en_ff[0]) ?
							`MMS_VEC_HI : `MMS_VEC_LO;
					end
					else if (cmd_go)
					begin
						op_ff <= cmd_in;
						case (cmd_in)
							CMD_PHA, CMD_PHP, CMD_JSR:
								state_ff <= ST_PUSH;
							CMD_PLA, CMD_PLP, CMD_RTS, CMD_RTI:
								state_ff <= ST_PULL;
							default: state_ff <= ST_IDLE;
						endcase
					end
				end
				ST_PUSH:
				begin
					step_ff <= step_ff + 2'h1;
					if (last_step)
						state_ff <= (op_ff == CMD_IRQ) ? ST_VEC : ST_IDLE;
				end
				ST_PULL:
				begin
					step_ff <= step_ff + 2'h1;
					if (last_step)
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end

	// stack pointer: deliberately left out of reset
	always_ff @(posedge pclk)
		if (cmd_go && !busy && cmd_in == CMD_TXS)
			sp_ff <= x_ff;
		else if (state_ff == ST_PUSH)
			sp_ff <= sp_ff - 8'h01;
		else if (state_ff == ST_PULL)
			sp_ff <= sp_ff + 8'h01;

	// program counter halves
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pc_ff <= 16'h0000;
		else if (wr_ok && paddr == `MMS_OFF_PC)
			pc_ff <= pwdata[15:0];
		else if (state_ff == ST_PUSH && op_ff == CMD_JSR && last_step)
			pc_ff <= {8'hFF, opnd_ff[7:0]};
		else if (state_ff == ST_VEC)
			pc_ff <= {mem_rd(vec_ff + 16'h0001), mem_rd(vec_ff)};
		else if (state_ff == ST_PULL && (op_ff == CMD_RTS ||
			op_ff == CMD_RTI))
		begin
			if (step_ff == n_bytes(op_ff) - 2'h2)
				pc_ff[7:0] <= pull_byte;
			else if (last_step)
				pc_ff[15:8] <= pull_byte;
		end

	// processor status: interrupt disable set once the push is done
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ps_ff <= `MMS_PS_RST;
		else if (wr_ok && paddr == `MMS_OFF_PSR)
			ps_ff <= pwdata[7:0];
		else if (state_ff == ST_VEC)
			ps_ff[`MMS_PS_I] <= 1'b1;
		else if (state_ff == ST_PULL && step_ff == 2'h0 &&
			(op_ff == CMD_PLP || op_ff == CMD_RTI))
			ps_ff <= pull_byte;

	// accumulator, index registers, operand and window address
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			acc_ff <= 8'h00;
			x_ff <= 8'h00;
			y_ff <= 8'h00;
			opnd_ff <= 16'h0000;
			addr_ff <= 16'h0000;
		end
		else if (state_ff == ST_PULL && op_ff == CMD_PLA)
			acc_ff <= pull_byte;
		else if (wr_ok)
			case (paddr)
				`MMS_OFF_ACC: acc_ff <= pwdata[7:0];
				`MMS_OFF_XREG: x_ff <= pwdata[7:0];
				`MMS_OFF_YREG: y_ff <= pwdata[7:0];
				`MMS_OFF_OPND: opnd_ff <= pwdata[15:0];
				`MMS_OFF_ADDR: addr_ff <= pwdata[15:0];
				default: acc_ff <= acc_ff;
			endcase

	////////////////////////////////////////////////////////////////////////
	// reset output held a least reset time after release
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rst_cnt_ff <= 7'h00;
			reset_out_n_ff <= 1'b0;
		end
		else
		begin
			if (rst_cnt_ff != 7'(`MMS_RST_CYC))
				rst_cnt_ff <= rst_cnt_ff + 7'h01;
			reset_out_n_ff <= rst_cnt_ff == 7'(`MMS_RST_CYC);
		end

	// serial data in comes off the synchronised port three pin
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			serial_data_in_ff <= 1'b0;
		else
			serial_data_in_ff <= pin_sync[3][4];

	////////////////////////////////////////////////////////////////////////
	// five bidirectional ports
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_port
			mms_port u_port (
				.pclk(pclk),
				.presetn(presetn),
				.dir(port_dir_ff[g]),
				.data(port_data_ff[g]),
				.alt_en((g == 3 && sio_sel) ? `MMS_SIO_PINS : 8'h00),
				.alt_oe(`MMS_SIO_OUTS),
				.alt_out({serial_ready, serial_clock, serial_data_out, 5'h00}),
				.pin_in(port_pin_in[8 * g +: 8]),
				.pin_out_ff(port_pin_out[8 * g +: 8]),
				.pin_oe_ff(port_pin_oe[8 * g +: 8]),
				.pin_sync_ff(pin_sync[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_irq_push;
		state_ff == ST_PUSH && op_ff == CMD_IRQ && step_ff == 2'h0;
	endsequence
	sequence s_rti_pull;
		state_ff == ST_PULL && op_ff == CMD_RTI && step_ff == 2'h0;
	endsequence
	a_irq_push_order: assert property (s_irq_push |->
		mw_data == pc_ff[15:8] ##1 mw_data == pc_ff[7:0] ##1
		mw_data == ps_ff ##1 state_ff == ST_VEC)
		else $error("interrupt push order wrong");
	a_push_decrement: assert property (state_ff == ST_PUSH |=>
		sp_ff == $past(sp_ff) - 8'h01)
		else $error("push did not decrement pointer");
	a_pull_increment: assert property (state_ff == ST_PULL |=>
		sp_ff == $past(sp_ff) + 8'h01)
		else $error("pull did not increment pointer");
	a_rti_reverse: assert property (s_rti_pull |=>
		ps_ff == $past(pull_byte) ##1 pc_ff[7:0] == $past(pull_byte)
		##1 pc_ff[15:8] == $past(pull_byte) && state_ff == ST_IDLE)
		else $error("return from interrupt order wrong");
	a_pla_restore: assert property (state_ff == ST_PULL &&
		op_ff == CMD_PLA |=> acc_ff == $past(pull_byte) && !busy)
		else $error("accumulator not restored");
	a_jsr_target: assert property (state_ff == ST_PUSH &&
		op_ff == CMD_JSR && step_ff == 2'h1 |=> pc_ff[15:8] == 8'hFF &&
		pc_ff[7:0] == $past(opnd_ff[7:0]) && !busy)
		else $error("special page call target wrong");
	a_stack_page: assert property (state_ff == ST_PUSH |->
		mw_addr[15:9] == 7'h00 && mw_addr[8] == tmr_ctl_ff[`MMS_STK_PAGE])
		else $error("stack page wrong");
	a_irq_priority: assert property (irq_take && req_hi_ff &&
		int_en_ff[0] |=> vec_ff == `MMS_VEC_HI ##3 state_ff == ST_VEC)
		else $error("high irq not preferred");
	a_serial_pins: assert property (sio_sel |=>
		port_pin_oe[31:28] == 4'hE)
		else $error("serial pins not taken over");
	a_dir_oe: assert property (##1 !$past(sio_sel) |->
		port_pin_oe[31:24] == $past(port_dir_ff[3]))
		else $error("port enable does not follow direction");
	a_reset_out: assert property (@(posedge pclk) disable iff (1'b0)
		!presetn |-> !reset_out_n_ff)
		else $error("reset output high during reset");
endmodule // mms_core

// file: tb/mms_board.sv
// board model: pin levels from device drive and board pattern
`timescale 1ns/100ps
module mms_board (
	input wire logic [39:0] drv, // device drive values
	input wire logic [39:0] oe, // device drive enables
	input wire logic [39:0] ext, // board level on undriven pins
	output logic [39:0] lvl // resolved pin levels
);
	// an undriven pin shows the board level, never the last drive
	assign lvl = (oe & drv) | (~oe & ext);
endmodule // mms_board

// file: tb/testbench.sv
// self-checking bench: apb access, memory map, stack engine, ports
`timescale 1ns/100ps
module testbench;
	import mms_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, input_only_port = 8'h3C;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [32:0] r; // error flag over read data
	logic pready, pslverr, serial_data_in, serial_select, reset_out_n;
	logic [39:0] port_pin_in, port_pin_out, port_pin_oe;
	logic external_irq_high_n = 1, external_irq_low_n = 1;
	logic serial_ready = 1, serial_clock = 0, serial_data_out = 1;
	int mismatches = 0, checks_done = 0, cyc = 0;
	logic [15:0] ra [9] = '{16'h0000, 16'h00BF, 16'h00C0, 16'h00FF,
		16'h0100, 16'hE7FF, 16'hE800, 16'hFFF3, 16'hFFF4};
	mms_region_t rg [9] = '{RG_RAM, RG_RAM, RG_SFR, RG_SFR, RG_NONE,
		RG_NONE, RG_ROM, RG_SPECIAL, RG_VECTOR};
	always #12.5 pclk = ~pclk;
	mms_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_pin_in(port_pin_in),
		.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
		.input_only_port(input_only_port),
		.external_irq_high_n(external_irq_high_n),
		.external_irq_low_n(external_irq_low_n),
		.serial_ready(serial_ready), .serial_clock(serial_clock),
		.serial_data_out(serial_data_out),
		.serial_data_in(serial_data_in), .serial_select(serial_select),
		.reset_out_n(reset_out_n));
	mms_board board (.drv(port_pin_out), .oe(port_pin_oe),
		.ext(40'h00_1000_003C), .lvl(port_pin_in));
	// hang guard: the run needs well under 2000 cycles
	always @(posedge pclk)
		if (++cyc == 5000)
			give_verdict(1);
	// one apb transfer; mode 0 read and compare, 1 write, 2 read only
	task automatic xf(input logic [1:0] m, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= (m == 1);
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = {pslverr, prdata};
		psel <= 0;
		penable <= 0;
		if (m == 0)
			chk(r, d);
	endtask
	task automatic chk(input logic [39:0] g, input logic [39:0] x);
		checks_done++;
		mismatches += (g !== x);
		if (g !== x)
			$display("BAD %0t got %h want %h", $time, g, x);
	endtask
	// set the window address, then access the window or status
	task automatic mem(input logic [1:0] m, input logic [15:0] a,
		input logic [31:0] x, input logic [7:0] o = 8'h04);
		xf(1, 8'h00, a);
		xf(m, o, x);
	endtask
	// write a command (or another register), wait until engine is idle
	task automatic run(input logic [3:0] c, input logic [7:0] o = 8'h20);
		xf(1, o, c);
		do xf(2, 8'h24, 32'h0); while (r[0] !== 1'b0);
	endtask
	task automatic give_verdict(input int extra);
		mismatches += extra;
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge pclk);
		chk(port_pin_oe | reset_out_n, 40'h0);
		presetn <= 1;
		repeat (90) @(posedge pclk);
		chk(reset_out_n, 40'h1);
		for (int i = 0; i < 9; i++)
			mem(0, ra[i], {rg[i], 1'b0}, 8'h24);
		xf(1, 8'h0C, 8'h9C);
		xf(1, 8'h10, 8'h71);
		xf(1, 8'h28, 16'hFF80);
		xf(0, 8'h2C, 32'hFFF1_001C);
		xf(1, 8'h0C, 8'hBF);
		run(4'h1);
		xf(1, 8'h08, 8'h5A);
		run(4'h2);
		xf(1, 8'h18, 8'hC5);
		run(4'h4);
		mem(0, 16'h00BF, 8'h5A);
		mem(0, 16'h00BE, 8'hC5);
		xf(1, 8'h18, 8'h04);
		xf(1, 8'h08, 8'h00);
		run(4'h5);
		xf(0, 8'h18, 8'hC5);
		run(4'h3);
		xf(0, 8'h08, 8'h5A);
		xf(1, 8'h1C, 16'h1234);
		xf(1, 8'h28, 16'h0056);
		run(4'h6);
		xf(0, 8'h1C, 16'hFF56);
		xf(0, 8'h14, 8'hBD);
		mem(0, 16'h00BF, 8'h12);
		run(4'h4);
		xf(1, 8'h18, 8'h04);
		run(4'h8);
		xf(0, 8'h1C, 16'h1234);
		xf(0, 8'h18, 8'hC5);
		// interrupts: vectors into the program image, both pins pulsed
		xf(1, 8'h1C, 16'h1357);
		mem(1, 16'hFFFC, 8'h80);
		mem(1, 16'hFFFD, 8'hFF);
		mem(1, 16'hFFF4, 8'h20);
		mem(1, 16'hFFF5, 8'hF0);
		mem(1, 16'h00FE, 8'h03);
		{external_irq_high_n, external_irq_low_n} <= 2'b00;
		repeat (2) @(posedge pclk);
		{external_irq_high_n, external_irq_low_n} <= 2'b11;
		mem(0, 16'h00FE, 8'h33);
		// clearing the disable flag lets the high request in at once
		run(4'h0, 8'h18);
		xf(0, 8'h1C, 16'hFF80);
		xf(0, 8'h18, 8'h04);
		xf(0, 8'h14, 8'hBC);
		mem(0, 16'h00BF, 8'h13);
		mem(0, 16'h00BE, 8'h57);
		mem(0, 16'h00BD, 8'h00);
		mem(0, 16'h00FE, 8'h23);
		// return clears the flag, so the low request follows it
		run(4'h8);
		xf(0, 8'h1C, 16'hF020);
		mem(0, 16'h00BE, 8'h57);
		mem(0, 16'h00FE, 8'h03);
		xf(1, 8'h18, 8'h24);
		xf(0, 8'h24, 32'h0000_BF02);
		mem(1, 16'h00C1, 8'hF0);
		mem(1, 16'h00C0, 8'hA5);
		repeat (2) @(posedge pclk);
		chk({port_pin_oe[7:0], port_pin_out[7:4]}, 12'hF0A);
		mem(0, 16'h00C0, 8'hAC);
		mem(0, 16'h00CA, 8'h3C);
		mem(1, 16'h00F6, 8'h04);
		repeat (4) @(posedge pclk);
		chk({serial_data_in, serial_select, port_pin_oe[31:29],
			port_pin_out[31:29]}, 8'hFD);
		// second reset mid-run, held past the least reset time
		presetn <= 0;
		repeat (81) @(posedge pclk);
		chk({port_pin_oe[31:24], serial_select, reset_out_n},
			10'h0);
		presetn <= 1;
		repeat (90) @(posedge pclk);
		chk(reset_out_n, 40'h1);
		xf(0, 8'h14, 8'hBC);
		xf(2, 8'h30, 32'h0);
		chk(r, 33'h1_0000_0000);
		give_verdict(0);
	end
endmodule // testbench
